// File: hdl/mtn_pkg.sv
// Function
// - two interrupt pins, both always driven push-pull, never left floating.
// - pins active high; invert bit in format register makes them active low.
// - source reaches a pin only if enabled; routing bit picks first or second pin.
// - event flags latched; overrun clears by data reads, activity and inactivity by source read.
// - data-ready set while an unread sample exists, cleared when none remains.
// - activity set when level exceeds activity threshold.
// - inactivity set when level stays below threshold longer than duration seconds.
// - watermark holds while buffer count is at or above a nonzero sample-count field.
// - overrun on unread overwrite in bypass, on full buffer otherwise.
// - 32-entry x/y/z buffer with four modes from buffer control.
// - bypass mode stores nothing, buffer stays empty.
// - fill-once mode stops at 32 entries; detection keeps running.
// - circular mode keeps newest 32, dropping the oldest when full.
// - trigger mode runs circular; trigger event routed by trigger-select bit.
// - after trigger keep newest n entries, then behave as fill-once.
// - further triggers ignored until host goes bypass then trigger.
// - entering bypass empties the buffer; host reads wanted data first.
// - each data read pops the oldest set into the output registers.
// - single-byte data read discards the remaining bytes of that set.
package mtn_pkg;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_ACT_THR    = 8'h24;
   localparam logic [7:0] ADDR_INACT_THR  = 8'h25;
   localparam logic [7:0] ADDR_INACT_DUR  = 8'h26;
   localparam logic [7:0] ADDR_INT_EN     = 8'h2E;
   localparam logic [7:0] ADDR_INT_MAP    = 8'h2F;
   localparam logic [7:0] ADDR_INT_SRC    = 8'h30;
   localparam logic [7:0] ADDR_FMT        = 8'h31;
   localparam logic [7:0] ADDR_DATA_FIRST = 8'h32;
   localparam logic [7:0] ADDR_DATA_LAST  = 8'h37;
   localparam logic [7:0] ADDR_BUF_CTL    = 8'h38;

   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int         FLAG_DRDY      = 7;
   localparam int         FLAG_ACT       = 4;
   localparam int         FLAG_INACT     = 3;
   localparam int         FLAG_WMARK     = 1;
   localparam int         FLAG_OVR       = 0;
   localparam int         FMT_INVERT     = 5;
   localparam int         BUF_MODE_LO    = 6;
   localparam int         BUF_TRIG_SEL   = 5;
   localparam logic [7:0] RST_BYTE       = 8'h00;
   localparam logic [7:0] UNMAPPED_BYTE  = 8'h00;

   // ----------------------------------------------------------------
   // buffer modes
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_BYPASS = 2'h0,
      MODE_FILL   = 2'h1,
      MODE_CIRC   = 2'h2,
      MODE_TRIG   = 2'h3
   } mtn_mode_t;

   // ----------------------------------------------------------------
   // sizes and timing
   // ----------------------------------------------------------------
   localparam int FIFO_DEPTH    = 32;
   localparam int CLK_PERIOD_NS = 4;
   localparam int INACT_UNIT_S  = 1;
   localparam int SEC_CYCLES    = INACT_UNIT_S * 1000000000 / CLK_PERIOD_NS;

endpackage

// File: hdl/mtn_irq_fifo.sv
`timescale 1ns/10ps
module mtn_irq_fifo #(
   parameter int DEPTH      = mtn_pkg::FIFO_DEPTH,
   parameter int SEC_CYCLES = mtn_pkg::SEC_CYCLES
) (
   input  logic        ref_clk,
   input  logic        reset,
   input  logic        link_clk,
   input  logic        link_reset,
   input  logic        lnk_req_valid,
   input  logic        lnk_req_write,
   input  logic        lnk_req_last,
   input  logic [7:0]  lnk_req_addr,
   input  logic [7:0]  lnk_req_wdata,
   output logic        lnk_req_ready,
   output logic        lnk_rsp_valid,
   output logic [7:0]  lnk_rsp_rdata,
   input  logic        smp_valid,
   input  logic [15:0] smp_x,
   input  logic [15:0] smp_y,
   input  logic [15:0] smp_z,
   input  logic [7:0]  smp_level,
   output logic        irq_pin_first,
   output logic        irq_pin_second
);

   localparam int PW = $clog2(DEPTH);
   localparam int CW = PW + 1;
   localparam int TW = $clog2(SEC_CYCLES + 1);

   // ----------------------------------------------------------------
   // parameter checks
   // ----------------------------------------------------------------
   generate
      if (DEPTH < 2 || (1 << PW) != DEPTH || SEC_CYCLES < 1) begin : g_bad_param
         $error("depth must be a power of two of at least 2, tick count at least 1");
      end
   endgenerate

   // ----------------------------------------------------------------
   // byte select from a stored x/y/z set
   // ----------------------------------------------------------------
   function automatic logic [7:0] pick_byte(input logic [47:0] s, input logic [2:0] k);
      logic [7:0] b;
      b = 8'h00;
      for (int i = 0; i < 6; i++) begin
         if (k == 3'(i)) begin
            b = s[8*i +: 8];
         end
      end
      return b;
   endfunction

   // link-domain request holding and handshake
   logic          l_pend_r, l_req_tgl_r, l_write_r, l_last_r;
   logic [7:0]    l_addr_r, l_wdata_r, l_rsp_rdata_r;
   logic          l_ack_s1_r, l_ack_s2_r, l_ack_s3_r, l_rsp_valid_r;
   // core-domain access side
   logic          c_req_s1_r, c_req_s2_r, c_req_s3_r, c_ack_tgl_r, acc_go;
   logic [7:0]    c_rdata_r;
   // registers
   logic [7:0]    act_thr_r, inact_thr_r, inact_dur_r, int_en_r, int_map_r, fmt_r, buf_ctl_r;
   // buffer
   logic [47:0]   mem [DEPTH];
   logic [PW-1:0] wr_ptr_r, rd_ptr_r;
   logic [CW-1:0] count_r;
   logic          trig_done_r, unread_r;
   logic [47:0]   out_set_r;
   // detection
   logic          still_r, inact_fired_r, act_flag_r, inact_flag_r, ovr_flag_r;
   logic [TW-1:0] tick_r;
   logic [8:0]    sec_cnt_r;
   logic          irq_first_r, irq_second_r;
   // combinational
   mtn_pkg::mtn_mode_t mode;
   logic [4:0]    n_samples;
   logic          trig_sel, full, fill_once, data_rd, pop_req, src_rd, bypass_entry;
   logic          pop_ok, push_ok, drop_old, act_evt, inact_evt, trig_evt, drdy, wmark;
   logic [7:0]    flags, rd_byte;
   logic [47:0]   head_set;

   // ----------------------------------------------------------------
   // link side: hold one request, toggle it across, wait for the ack
   // ----------------------------------------------------------------
   assign lnk_req_ready = !l_pend_r;
   assign lnk_rsp_valid = l_rsp_valid_r;
   assign lnk_rsp_rdata = l_rsp_rdata_r;

   // request capture, released by the returning ack
   always_ff @(posedge link_clk) begin
      if (link_reset) begin
         l_pend_r    <= 1'b0;
         l_req_tgl_r <= 1'b0;
         l_write_r   <= 1'b0;
         l_last_r    <= 1'b0;
         l_addr_r    <= 8'h00;
         l_wdata_r   <= 8'h00;
      end else if (lnk_req_valid && !l_pend_r) begin
         l_pend_r    <= 1'b1;
         l_req_tgl_r <= !l_req_tgl_r;
         l_write_r   <= lnk_req_write;
         l_last_r    <= lnk_req_last;
         l_addr_r    <= lnk_req_addr;
         l_wdata_r   <= lnk_req_wdata;
      end else if (l_ack_s2_r != l_ack_s3_r) begin
         l_pend_r    <= 1'b0;
      end
   end

   // ack toggle synchroniser into the link domain
   always_ff @(posedge link_clk) begin
      if (link_reset) begin
         l_ack_s1_r <= 1'b0;
         l_ack_s2_r <= 1'b0;
         l_ack_s3_r <= 1'b0;
      end else begin
         l_ack_s1_r <= c_ack_tgl_r;
         l_ack_s2_r <= l_ack_s1_r;
         l_ack_s3_r <= l_ack_s2_r;
      end
   end

   // answer pulse; core read data is held stable until the next answer
   always_ff @(posedge link_clk) begin
      if (link_reset) begin
         l_rsp_valid_r <= 1'b0;
         l_rsp_rdata_r <= 8'h00;
      end else begin
         l_rsp_valid_r <= l_ack_s2_r != l_ack_s3_r;
         if (l_ack_s2_r != l_ack_s3_r) begin
            l_rsp_rdata_r <= c_rdata_r;
         end
      end
   end

   // ----------------------------------------------------------------
   // core side: request toggle synchroniser and access execution
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         c_req_s1_r <= 1'b0;
         c_req_s2_r <= 1'b0;
         c_req_s3_r <= 1'b0;
      end else begin
         c_req_s1_r <= l_req_tgl_r;
         c_req_s2_r <= c_req_s1_r;
         c_req_s3_r <= c_req_s2_r;
      end
   end

   assign acc_go = c_req_s2_r != c_req_s3_r;

   // read data capture and ack toggle back
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         c_ack_tgl_r <= 1'b0;
         c_rdata_r   <= 8'h00;
      end else if (acc_go) begin
         c_ack_tgl_r <= !c_ack_tgl_r;
         if (!l_write_r) begin
            c_rdata_r <= rd_byte;
         end
      end
   end

   // ----------------------------------------------------------------
   // writable registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         act_thr_r   <= mtn_pkg::RST_BYTE;
         inact_thr_r <= mtn_pkg::RST_BYTE;
         inact_dur_r <= mtn_pkg::RST_BYTE;
         int_en_r    <= mtn_pkg::RST_BYTE;
         int_map_r   <= mtn_pkg::RST_BYTE;
         fmt_r       <= mtn_pkg::RST_BYTE;
         buf_ctl_r   <= mtn_pkg::RST_BYTE;
      end else if (acc_go && l_write_r) begin
         unique case (l_addr_r)
            mtn_pkg::ADDR_ACT_THR:   act_thr_r   <= l_wdata_r;
            mtn_pkg::ADDR_INACT_THR: inact_thr_r <= l_wdata_r;
            mtn_pkg::ADDR_INACT_DUR: inact_dur_r <= l_wdata_r;
            mtn_pkg::ADDR_INT_EN:    int_en_r    <= l_wdata_r;
            mtn_pkg::ADDR_INT_MAP:   int_map_r   <= l_wdata_r;
            mtn_pkg::ADDR_FMT:       fmt_r       <= l_wdata_r;
            mtn_pkg::ADDR_BUF_CTL:   buf_ctl_r   <= l_wdata_r;
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // decode of control fields and access kinds
   // ----------------------------------------------------------------
   assign mode      = mtn_pkg::mtn_mode_t'(buf_ctl_r[mtn_pkg::BUF_MODE_LO +: 2]);
   assign n_samples = buf_ctl_r[4:0];
   assign trig_sel  = buf_ctl_r[mtn_pkg::BUF_TRIG_SEL];
   assign data_rd   = acc_go && !l_write_r && l_addr_r >= mtn_pkg::ADDR_DATA_FIRST
                      && l_addr_r <= mtn_pkg::ADDR_DATA_LAST;
   // a read ends the set on its last byte or when the transfer stops early
   assign pop_req   = data_rd && (l_last_r || l_addr_r == mtn_pkg::ADDR_DATA_LAST);
   assign src_rd    = acc_go && !l_write_r && l_addr_r == mtn_pkg::ADDR_INT_SRC;
   assign bypass_entry = acc_go && l_write_r && l_addr_r == mtn_pkg::ADDR_BUF_CTL
                      && l_wdata_r[mtn_pkg::BUF_MODE_LO +: 2] == mtn_pkg::MODE_BYPASS;

   // ----------------------------------------------------------------
   // activity and inactivity detection
   // ----------------------------------------------------------------
   assign act_evt   = smp_valid && smp_level > act_thr_r;
   assign inact_evt = still_r && !inact_fired_r && sec_cnt_r > {1'b0, inact_dur_r};

   // quiet state follows the latest sample
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         still_r <= 1'b0;
      end else if (smp_valid) begin
         still_r <= smp_level < inact_thr_r;
      end
   end

   // whole seconds spent quiet, saturating above the 255 s limit
   always_ff @(posedge ref_clk) begin
      if (reset || !still_r) begin
         tick_r    <= '0;
         sec_cnt_r <= 9'h000;
      end else if (tick_r == TW'(SEC_CYCLES - 1)) begin
         tick_r <= '0;
         if (sec_cnt_r != 9'h1FF) begin
            sec_cnt_r <= sec_cnt_r + 9'h001;
         end
      end else begin
         tick_r <= tick_r + TW'(1);
      end
   end

   // one inactivity event per quiet stretch
   always_ff @(posedge ref_clk) begin
      if (reset || !still_r) begin
         inact_fired_r <= 1'b0;
      end else if (inact_evt) begin
         inact_fired_r <= 1'b1;
      end
   end

   // trigger from a source routed to the selected pin, once per arming
   assign trig_evt = mode == mtn_pkg::MODE_TRIG && !trig_done_r
                     && ((act_evt && int_map_r[mtn_pkg::FLAG_ACT] == trig_sel)
                     || (inact_evt && int_map_r[mtn_pkg::FLAG_INACT] == trig_sel));

   // ----------------------------------------------------------------
   // sample buffer
   // ----------------------------------------------------------------
   assign full      = count_r == CW'(DEPTH);
   assign fill_once = mode == mtn_pkg::MODE_FILL
                      || (mode == mtn_pkg::MODE_TRIG && trig_done_r);
   assign pop_ok    = pop_req && mode != mtn_pkg::MODE_BYPASS && count_r != '0 && !trig_evt;
   assign push_ok   = smp_valid && mode != mtn_pkg::MODE_BYPASS && !trig_evt
                      && !(fill_once && full && !pop_ok);
   assign drop_old  = push_ok && full && !pop_ok;

   // sample storage
   always_ff @(posedge ref_clk) begin
      if (push_ok) begin
         mem[wr_ptr_r] <= {smp_z, smp_y, smp_x};
      end
   end

   // pointers and fill count
   always_ff @(posedge ref_clk) begin
      if (reset || bypass_entry) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end else if (trig_evt) begin
         if (count_r > CW'(n_samples)) begin
            rd_ptr_r <= wr_ptr_r - PW'(n_samples);
            count_r  <= CW'(n_samples);
         end
      end else begin
         if (push_ok) begin
            wr_ptr_r <= wr_ptr_r + PW'(1);
         end
         if (pop_ok || drop_old) begin
            rd_ptr_r <= rd_ptr_r + PW'(1);
         end
         if (push_ok && !drop_old && !pop_ok) begin
            count_r <= count_r + CW'(1);
         end else if (pop_ok && !push_ok) begin
            count_r <= count_r - CW'(1);
         end
      end
   end

   // trigger lock, released only by going through bypass
   always_ff @(posedge ref_clk) begin
      if (reset || bypass_entry) begin
         trig_done_r <= 1'b0;
      end else if (trig_evt) begin
         trig_done_r <= 1'b1;
      end
   end

   // bypass output set and its unread marker; a new sample wins over a read
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         out_set_r <= 48'h0000_0000_0000;
         unread_r  <= 1'b0;
      end else if (smp_valid && mode == mtn_pkg::MODE_BYPASS) begin
         out_set_r <= {smp_z, smp_y, smp_x};
         unread_r  <= 1'b1;
      end else if (pop_req || bypass_entry) begin
         unread_r  <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // latched flags; set wins over clear by reads
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         act_flag_r   <= 1'b0;
         inact_flag_r <= 1'b0;
      end else begin
         act_flag_r   <= act_evt || (act_flag_r && !src_rd);
         inact_flag_r <= inact_evt || (inact_flag_r && !src_rd);
      end
   end

   // overrun: unread overwrite in bypass, full buffer in other modes
   always_ff @(posedge ref_clk) begin
      if (reset || bypass_entry) begin
         ovr_flag_r <= 1'b0;
      end else if (mode == mtn_pkg::MODE_BYPASS ? (smp_valid && unread_r)
                                                 : (full && !pop_ok)) begin
         ovr_flag_r <= 1'b1;
      end else if (pop_req) begin
         ovr_flag_r <= 1'b0;
      end
   end

   // data flags follow the data state and fall once reads drain it
   assign drdy  = mode == mtn_pkg::MODE_BYPASS ? unread_r : count_r != '0;
   assign wmark = mode != mtn_pkg::MODE_BYPASS && n_samples != 5'h00
                  && count_r >= CW'(n_samples);

   // flag byte as read from the source register
   always_comb begin
      flags                        = 8'h00;
      flags[mtn_pkg::FLAG_DRDY]    = drdy;
      flags[mtn_pkg::FLAG_ACT]     = act_flag_r;
      flags[mtn_pkg::FLAG_INACT]   = inact_flag_r;
      flags[mtn_pkg::FLAG_WMARK]   = wmark;
      flags[mtn_pkg::FLAG_OVR]     = ovr_flag_r;
   end

   // ----------------------------------------------------------------
   // interrupt pins
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         irq_first_r  <= 1'b0;
         irq_second_r <= 1'b0;
      end else begin
         irq_first_r  <= (|(flags & int_en_r & ~int_map_r)) ^ fmt_r[mtn_pkg::FMT_INVERT];
         irq_second_r <= (|(flags & int_en_r & int_map_r)) ^ fmt_r[mtn_pkg::FMT_INVERT];
      end
   end

   // both pins always driven
   assign irq_pin_first  = irq_first_r;
   assign irq_pin_second = irq_second_r;

   // ----------------------------------------------------------------
   // register read path
   // ----------------------------------------------------------------
   assign head_set = mode == mtn_pkg::MODE_BYPASS ? out_set_r
                   : (count_r != '0 ? mem[rd_ptr_r] : 48'h0000_0000_0000);

   // read multiplexer
   always_comb begin
      rd_byte = mtn_pkg::UNMAPPED_BYTE;
      unique case (l_addr_r)
         mtn_pkg::ADDR_ACT_THR:   rd_byte = act_thr_r;
         mtn_pkg::ADDR_INACT_THR: rd_byte = inact_thr_r;
         mtn_pkg::ADDR_INACT_DUR: rd_byte = inact_dur_r;
         mtn_pkg::ADDR_INT_EN:    rd_byte = int_en_r;
         mtn_pkg::ADDR_INT_MAP:   rd_byte = int_map_r;
         mtn_pkg::ADDR_INT_SRC:   rd_byte = flags;
         mtn_pkg::ADDR_FMT:       rd_byte = fmt_r;
         mtn_pkg::ADDR_BUF_CTL:   rd_byte = buf_ctl_r;
         default: begin
            if (l_addr_r >= mtn_pkg::ADDR_DATA_FIRST && l_addr_r <= mtn_pkg::ADDR_DATA_LAST) begin
               rd_byte = pick_byte(head_set, 3'(l_addr_r - mtn_pkg::ADDR_DATA_FIRST));
            end
         end
      endcase
   end

endmodule

// File: testbench/mtn_irq_fifo_assertions.sv
`timescale 1ns/10ps
// ----------------------------------------------
// link handshake, register and pin checks
// ----------------------------------------------
module mtn_irq_fifo_checker (
   input logic       ref_clk,
   input logic       reset,
   input logic       link_clk,
   input logic       link_reset,
   input logic       lnk_req_valid,
   input logic       lnk_req_write,
   input logic [7:0] lnk_req_addr,
   input logic [7:0] lnk_req_wdata,
   input logic       lnk_req_ready,
   input logic       lnk_rsp_valid,
   input logic [7:0] lnk_rsp_rdata,
   input logic       irq_pin_first,
   input logic       irq_pin_second
);
   logic [7:0] sh_r [0:255];
   logic [7:0] a_r;
   logic [7:0] d_r;
   logic       w_r;
   logic       take;
   logic       rw_a;
   logic       map_a;
   assign take  = lnk_req_valid & lnk_req_ready;
   assign rw_a  = a_r inside {8'h24, 8'h25, 8'h26, 8'h2E, 8'h2F, 8'h31, 8'h38};
   assign map_a = rw_a | (a_r inside {[8'h30:8'h37]});
   // request in flight
   always_ff @(posedge link_clk) begin
      if (link_reset) begin
         a_r <= 8'h00;
         d_r <= 8'h00;
         w_r <= 1'b0;
      end else if (take) begin
         a_r <= lnk_req_addr;
         d_r <= lnk_req_wdata;
         w_r <= lnk_req_write;
      end
   end
   // bytes written, applied at the answer
   always_ff @(posedge link_clk) begin
      if (link_reset) begin
         sh_r <= '{default: 8'h00};
      end else if (lnk_rsp_valid && w_r) begin
         sh_r[a_r] <= d_r;
      end
   end
   property p_take_busy;
      @(posedge link_clk) disable iff (link_reset) take |=> !lnk_req_ready;
   endproperty
   a_take_busy: assert property (p_take_busy) else $error("ready after take");
   property p_rsp_bound;
      @(posedge link_clk) disable iff (link_reset) take |-> ##[3:7] lnk_rsp_valid;
   endproperty
   a_rsp_bound: assert property (p_rsp_bound) else $error("answer late");
   property p_rsp_pulse;
      @(posedge link_clk) disable iff (link_reset) lnk_rsp_valid |=> !lnk_rsp_valid;
   endproperty
   a_rsp_pulse: assert property (p_rsp_pulse) else $error("answer too long");
   property p_rsp_ready;
      @(posedge link_clk) disable iff (link_reset)
         lnk_rsp_valid |-> lnk_req_ready && !$past(lnk_req_ready);
   endproperty
   a_rsp_ready: assert property (p_rsp_ready) else $error("ready not with answer");
   property p_rdata_hold;
      @(posedge link_clk) disable iff (link_reset) !lnk_rsp_valid |-> $stable(lnk_rsp_rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
   property p_readback;
      @(posedge link_clk) disable iff (link_reset)
         lnk_rsp_valid && !w_r && rw_a |-> lnk_rsp_rdata == sh_r[a_r];
   endproperty
   a_readback: assert property (p_readback) else $error("readback differs");
   property p_unmapped;
      @(posedge link_clk) disable iff (link_reset)
         lnk_rsp_valid && !w_r && !map_a |-> lnk_rsp_rdata == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_pins_idle;
      @(posedge link_clk) disable iff (link_reset)
         lnk_req_ready && !lnk_rsp_valid && sh_r[8'h2E] == 8'h00 |->
         irq_pin_first == sh_r[8'h31][5] && irq_pin_second == sh_r[8'h31][5];
   endproperty
   a_pins_idle: assert property (p_pins_idle) else $error("masked pin active");
   property p_pins_reset;
      @(posedge ref_clk) disable iff (reset) $fell(reset) |-> !irq_pin_first && !irq_pin_second;
   endproperty
   a_pins_reset: assert property (p_pins_reset) else $error("pin active after reset");
   c_write: cover property (@(posedge link_clk) take && lnk_req_write);
   c_src_rd: cover property (@(posedge link_clk) lnk_rsp_valid && !w_r && a_r == 8'h30);
   c_pin: cover property (@(posedge ref_clk) $rose(irq_pin_first));
endmodule
bind mtn_irq_fifo mtn_irq_fifo_checker u_chk (.ref_clk, .reset, .link_clk, .link_reset,
   .lnk_req_valid, .lnk_req_write, .lnk_req_addr, .lnk_req_wdata, .lnk_req_ready,
   .lnk_rsp_valid, .lnk_rsp_rdata, .irq_pin_first, .irq_pin_second);

// File: testbench/mtn_host_model.sv
`timescale 1ns/10ps
// host processor on the register link
module mtn_host_model (
   input  logic       link_clk,
   output logic       lnk_req_valid,
   output logic       lnk_req_write,
   output logic       lnk_req_last,
   output logic [7:0] lnk_req_addr,
   output logic [7:0] lnk_req_wdata,
   input  logic       lnk_req_ready,
   input  logic       lnk_rsp_valid,
   input  logic [7:0] lnk_rsp_rdata
);
   // idle link at time zero
   initial begin
      lnk_req_valid = 1'b0;
      lnk_req_write = 1'b0;
      lnk_req_last  = 1'b1;
      lnk_req_addr  = 8'h00;
      lnk_req_wdata = 8'h00;
   end
   // one byte: held until taken, then wait for the answer
   task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
      int n;
      n = 0;
      @(posedge link_clk);
      lnk_req_valid <= 1'b1;
      lnk_req_write <= w;
      lnk_req_addr  <= a;
      lnk_req_wdata <= d;
      do @(negedge link_clk); while (lnk_req_ready !== 1'b1 && n++ < 99);
      @(posedge link_clk);
      lnk_req_valid <= 1'b0;
      lnk_req_addr  <= ~a;    // released lines drop the value
      lnk_req_wdata <= ~d;
      do @(negedge link_clk); while (lnk_rsp_valid !== 1'b1 && n++ < 99);
      q = lnk_rsp_rdata;
      @(posedge link_clk);
      if (!w && a inside {[8'h32:8'h37]})
         repeat (32) @(posedge link_clk);
   endtask
endmodule

// File: testbench/mtn_irq_fifo_test.sv
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
   $display("wrong value t=%0t got=%h exp=%h", $time, g, e); end end
// ----------------------------------------------
// bench
// ----------------------------------------------
module mtn_irq_fifo_test;
   typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} mtn_row_t;
   mtn_row_t    rows [6] = '{'{8'h24, 8'h80, 8'h80}, '{8'h25, 8'h3C, 8'h3C},
      '{8'h26, 8'h02, 8'h02}, '{8'h2F, 8'hA5, 8'hA5}, '{8'h31, 8'h0B, 8'h0B},
      '{8'h10, 8'h5A, 8'h00}};
   int          n_fail = 0;
   int          num_checks = 0;
   logic        ref_clk = 1'b0;
   logic        link_clk = 1'b0;
   logic        reset = 1'b1;
   logic        link_reset = 1'b1;
   logic        smp_valid = 1'b0;
   logic [15:0] smp_x = 16'h0000;
   logic [15:0] smp_y = 16'h0000;
   logic [15:0] smp_z = 16'h0000;
   logic [7:0]  smp_level = 8'h00;
   logic [7:0]  lnk_req_addr, lnk_req_wdata, lnk_rsp_rdata, q;
   logic        lnk_req_valid, lnk_req_write, lnk_req_last, lnk_req_ready;
   logic        lnk_rsp_valid, irq_pin_first, irq_pin_second;
   mtn_irq_fifo #(.SEC_CYCLES(20)) u_dut (.ref_clk, .reset, .link_clk, .link_reset,
      .lnk_req_valid, .lnk_req_write, .lnk_req_last, .lnk_req_addr, .lnk_req_wdata,
      .lnk_req_ready, .lnk_rsp_valid, .lnk_rsp_rdata, .smp_valid, .smp_x, .smp_y,
      .smp_z, .smp_level, .irq_pin_first, .irq_pin_second);
   mtn_host_model u_host (.link_clk, .lnk_req_valid, .lnk_req_write, .lnk_req_last,
      .lnk_req_addr, .lnk_req_wdata, .lnk_req_ready, .lnk_rsp_valid, .lnk_rsp_rdata);
   // clocks and resets
   always #2 ref_clk = ~ref_clk;
   always #80 link_clk = ~link_clk;
   task automatic wr(input logic [7:0] a, d);
      u_host.xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, e);
      u_host.xfer(1'b0, a, 8'h00, q);
      `CHK(q, e)
   endtask
   // one sample, axes tagged with its index
   task automatic smp(input logic [7:0] k, lv);
      @(posedge ref_clk);
      smp_valid <= 1'b1;
      {smp_x, smp_y, smp_z, smp_level} <= {8'h11, k, 8'h22, k, 8'h33, k, lv};
      @(posedge ref_clk);
      smp_valid <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask
   task automatic burst(input int n);
      for (int k = 0; k < n; k++) smp(8'(k), 8'h00);
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // watchdog
   initial begin
      #200000;
      n_fail++;
      results();
   end
   // main sequence
   initial begin
      repeat (5) @(posedge ref_clk);
      reset <= 1'b0;
      repeat (4) @(posedge link_clk);
      link_reset <= 1'b0;
      `CHK({irq_pin_second, irq_pin_first}, 2'b00)
      foreach (rows[i]) begin
         rd(rows[i].a, 8'h00);
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, rows[i].e);
      end
      wr(8'h25, 8'h00);
      wr(8'h2F, 8'h00);
      wr(8'h38, 8'h44);
      burst(33);
      wr(8'h2E, 8'h02);
      rd(8'h30, 8'h83);
      `CHK({irq_pin_second, irq_pin_first}, 2'b01)
      wr(8'h31, 8'h20);
      `CHK({irq_pin_second, irq_pin_first}, 2'b10)
      wr(8'h31, 8'h00);
      wr(8'h2E, 8'h00);
      wr(8'h2F, 8'h02);
      wr(8'h2E, 8'h02);
      `CHK({irq_pin_second, irq_pin_first}, 2'b10)
      rd(8'h32, 8'h00);
      rd(8'h32, 8'h01);
      rd(8'h30, 8'h82);
      wr(8'h38, 8'h00);
      u_host.xfer(1'b0, 8'h30, 8'h00, q);
      `CHK(q & 8'h03, 8'h00)
      wr(8'h38, 8'h84);
      burst(33);
      rd(8'h32, 8'h01);
      wr(8'h38, 8'h00);
      wr(8'h2E, 8'h00);
      wr(8'h2F, 8'h00);
      wr(8'h38, 8'hC4);
      wr(8'h2E, 8'h10);
      burst(10);
      smp(8'h0A, 8'h90);
      repeat (32) @(posedge link_clk);
      `CHK(irq_pin_first, 1'b1)
      rd(8'h32, 8'h06);
      rd(8'h30, 8'h90);
      `CHK(irq_pin_first, 1'b0)
      wr(8'h38, 8'h00);
      wr(8'h2E, 8'h00);
      wr(8'h25, 8'h10);
      wr(8'h2E, 8'h08);
      smp(8'h00, 8'h00);
      repeat (50) @(negedge ref_clk);
      `CHK(irq_pin_first, 1'b0)
      repeat (20) @(negedge ref_clk);
      `CHK(irq_pin_first, 1'b1)
      rd(8'h33, 8'h11);
      {reset, link_reset} <= 2'b11;
      repeat (3) @(posedge link_clk);
      {reset, link_reset} <= 2'b00;
      `CHK({irq_pin_second, irq_pin_first}, 2'b00)
      rd(8'h30, 8'h00);
      rd(8'h2E, 8'h00);
      results();
   end
endmodule
